// >>> common/vc_resource_defines.svh
// Offsets, field positions, reset values and codes of the VC resource registers
`ifndef VC_RESOURCE_DEFINES_SVH
`define VC_RESOURCE_DEFINES_SVH

`define VC_CTRL0_OFFS 12'h154
`define VC_STAT0_OFFS 12'h158
`define VC_CAP1_OFFS 12'h15c

`define TC_MAP_MSB 7
`define TC_MAP_LSB 0
`define LOAD_BIT 16
`define SEL_MSB 19
`define SEL_LSB 17
`define VCID_MSB 26
`define VCID_LSB 24
`define EN_BIT 31

`define TBL_ST_BIT 16
`define NEG_BIT 17

`define CAP_ARB_MSB 7
`define CAP_ARB_LSB 0
`define AS_BIT 14
`define SNOOP_BIT 15
`define SLOTS_MSB 22
`define SLOTS_LSB 16
`define TOFF_MSB 31
`define TOFF_LSB 24

`define TC_MAP_RST 8'hff
`define EN_RST 1'b1
`define VCID_VAL 3'h0
`define CAP_ARB_EXT 8'h19
`define CAP_ARB_NONE 8'h00
`define SLOTS_RST 7'h7f
`define SLOTS_NONE 7'h00
`define TOFF_EXT 8'h08
`define TOFF_NONE 8'h00

// Bits reserved in all three words, read back as zero
`define RSVD_COMMON_MASK 32'h00803f00

`define ARB_HW_FIXED 3'h0
`define ARB_WRR128 3'h3
`define ARB_TBWRR128 3'h4

`define BYTE_TC 0
`define BYTE_SEL 2
`define BYTE_EN 3

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> common/vc_resource_pkg.sv
// Types shared by the VC resource register slice
`include "vc_resource_defines.svh"
package vc_resource_pkg;
    typedef enum logic [2:0]
    {
        arb_hw_fixed = `ARB_HW_FIXED,
        arb_wrr128 = `ARB_WRR128,
        arb_tbwrr128 = `ARB_TBWRR128
    } arb_scheme_type;
    typedef logic [31:0] word_type;
endpackage

// >>> verilog/vc_resource_config_regs.sv
// AXI4-Lite register slice for VC0 control and status and VC1 capability
//
// Function
// - Each bit of the TC map marks one traffic class carried on VC0.
// - TC map resets to FFh; EEPROM autoload may replace it.
// - Writing one to load bit pulses table load; bit reads zero, resets zero.
// - Scheme select keeps supported codes only; others become default; resets 000b.
// - VC0 identifier is read-only and always reads zero.
// - Top control bit enables the channel; resets to enabled.
// - Table status sets on table writes, clears on load done, resets zero.
// - Negotiation pending follows negotiation in progress; resets zero.
// - VC1 arbitration capability reads 19h when extended VC set, else 00h.
// - Offer fixed, WRR128 and time-based WRR128; time-based only on VC1.
// - VC1 advanced-switching and snoop-reject bits read zero.
// - VC1 max time slots reads 7Fh or EEPROM value when extended, else zero.
// - VC1 table offset reads 08h when extended VC set, else 00h.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "vc_resource_defines.svh"

module vc_resource_config_regs
#(
    parameter int ADDR_WIDTH = 12,
    parameter int TC_MAP_WIDTH = 8
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // AXI4-Lite write address
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Extended VC bit from the register at 144h
    input wire logic ext_vc_en,
    // EEPROM autoload
    input wire logic autoload_valid,
    input wire logic [TC_MAP_WIDTH-1:0] autoload_tc_map,
    input wire logic [6:0] autoload_max_slots,
    // Port arbitration table and hardware
    input wire logic pat_entry_wr,
    input wire logic pat_load_done,
    output logic pat_load,
    // VC negotiation
    input wire logic vc_negotiating,
    // Configuration to the port
    output logic [TC_MAP_WIDTH-1:0] tc_map,
    output logic [2:0] arb_select,
    output logic vc_enable
);

    generate
        if (ADDR_WIDTH < 9 || ADDR_WIDTH > 32 || TC_MAP_WIDTH != 8)
        begin : g_bad_param
            $error("vc_resource_config_regs: unsupported parameter value");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic addr_hit(input logic [ADDR_WIDTH-1:0] addr, input logic [11:0] offs);
        addr_hit = ({addr[ADDR_WIDTH-1:2], 2'b00} == ADDR_WIDTH'(offs));
    endfunction

    function automatic vc_resource_pkg::arb_scheme_type vc0_scheme(input logic [2:0] code);
        // Time-based WRR is a VC1 scheme, so VC0 falls back to the default
        if (code == `ARB_WRR128)
        begin
            vc0_scheme = vc_resource_pkg::arb_wrr128;
        end
        else
        begin
            vc0_scheme = vc_resource_pkg::arb_hw_fixed;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [ADDR_WIDTH-1:0] awaddr_ff;
    logic aw_held_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic w_held_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [TC_MAP_WIDTH-1:0] tc_map_ff;
    vc_resource_pkg::arb_scheme_type arb_sel_ff;
    logic vc_en_ff;
    logic pat_load_ff;
    logic tbl_status_ff;
    logic neg_pend_ff;
    logic [6:0] max_slots_ff;
    logic wr_fire;
    logic wr_ctrl;
    logic wr_mapped;
    logic ar_take;
    vc_resource_pkg::word_type ctrl_word;
    vc_resource_pkg::word_type stat_word;
    vc_resource_pkg::word_type cap_word;
    vc_resource_pkg::word_type nxt_rdata;
    logic [1:0] nxt_rresp;

    ////////////////////////////////////////////////////////////////////////////
    // Write channels

    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready = !w_held_ff && !bvalid_ff;
    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_ctrl = wr_fire && addr_hit(awaddr_ff, `VC_CTRL0_OFFS);
    assign wr_mapped = addr_hit(awaddr_ff, `VC_CTRL0_OFFS) || addr_hit(awaddr_ff, `VC_STAT0_OFFS)
        || addr_hit(awaddr_ff, `VC_CAP1_OFFS);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            aw_held_ff <= 1'b0;
            awaddr_ff <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end
        else if (wr_fire)
        begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            w_held_ff <= 1'b0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end
        else if (wr_fire)
        begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    ////////////////////////////////////////////////////////////////////////////
    // VC0 control fields

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            tc_map_ff <= `TC_MAP_RST;
        end
        else if (wr_ctrl && wstrb_ff[`BYTE_TC])
        begin
            tc_map_ff <= wdata_ff[`TC_MAP_MSB:`TC_MAP_LSB];
        end
        else if (autoload_valid)
        begin
            tc_map_ff <= autoload_tc_map;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            arb_sel_ff <= vc_resource_pkg::arb_hw_fixed;
        end
        else if (wr_ctrl && wstrb_ff[`BYTE_SEL])
        begin
            arb_sel_ff <= vc0_scheme(wdata_ff[`SEL_MSB:`SEL_LSB]);
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pat_load_ff <= 1'b0;
        end
        else
        begin
            pat_load_ff <= wr_ctrl && wstrb_ff[`BYTE_SEL] && wdata_ff[`LOAD_BIT];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            vc_en_ff <= `EN_RST;
        end
        else if (wr_ctrl && wstrb_ff[`BYTE_EN])
        begin
            vc_en_ff <= wdata_ff[`EN_BIT];
        end
    end

    assign tc_map = tc_map_ff;
    assign arb_select = arb_sel_ff;
    assign vc_enable = vc_en_ff;
    assign pat_load = pat_load_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Status and capability state

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            tbl_status_ff <= 1'b0;
        end
        else if (pat_entry_wr)
        begin
            tbl_status_ff <= 1'b1;
        end
        else if (pat_load_done)
        begin
            tbl_status_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            neg_pend_ff <= 1'b0;
        end
        else
        begin
            neg_pend_ff <= vc_negotiating;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            max_slots_ff <= `SLOTS_RST;
        end
        else if (autoload_valid)
        begin
            max_slots_ff <= autoload_max_slots;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read words, reserved bits zero

    always_comb
    begin
        ctrl_word = '0;
        ctrl_word[`TC_MAP_MSB:`TC_MAP_LSB] = tc_map_ff;
        ctrl_word[`LOAD_BIT] = 1'b0;
        ctrl_word[`SEL_MSB:`SEL_LSB] = arb_sel_ff;
        ctrl_word[`VCID_MSB:`VCID_LSB] = `VCID_VAL;
        ctrl_word[`EN_BIT] = vc_en_ff;
    end

    always_comb
    begin
        stat_word = '0;
        stat_word[`TBL_ST_BIT] = tbl_status_ff;
        stat_word[`NEG_BIT] = neg_pend_ff;
    end

    always_comb
    begin
        cap_word = '0;
        cap_word[`CAP_ARB_MSB:`CAP_ARB_LSB] = ext_vc_en ? `CAP_ARB_EXT : `CAP_ARB_NONE;
        cap_word[`AS_BIT] = 1'b0;
        cap_word[`SNOOP_BIT] = 1'b0;
        cap_word[`SLOTS_MSB:`SLOTS_LSB] = ext_vc_en ? max_slots_ff : `SLOTS_NONE;
        cap_word[`TOFF_MSB:`TOFF_LSB] = ext_vc_en ? `TOFF_EXT : `TOFF_NONE;
    end

    always_comb
    begin
        nxt_rdata = '0;
        nxt_rresp = `RESP_OKAY;
        if (addr_hit(s_axi_araddr, `VC_CTRL0_OFFS))
        begin
            nxt_rdata = ctrl_word;
        end
        else if (addr_hit(s_axi_araddr, `VC_STAT0_OFFS))
        begin
            nxt_rdata = stat_word;
        end
        else if (addr_hit(s_axi_araddr, `VC_CAP1_OFFS))
        begin
            nxt_rdata = cap_word;
        end
        else
        begin
            nxt_rresp = `RESP_SLVERR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channels

    assign s_axi_arready = !rvalid_ff;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= `RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
        else if (s_axi_rready)
        begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_load_write;
        wr_ctrl && wstrb_ff[`BYTE_SEL] && wdata_ff[`LOAD_BIT];
    endsequence

    sequence s_load_pulse;
        pat_load ##1 !pat_load;
    endsequence

    property p_load_pulse;
        @(posedge clock) disable iff (!rst_n)
        s_load_write |=> s_load_pulse;
    endproperty
    a_load_pulse: assert property (p_load_pulse) else $error("table load pulse missing");

    property p_load_reads_zero;
        @(posedge clock) disable iff (!rst_n)
        ar_take && addr_hit(s_axi_araddr, `VC_CTRL0_OFFS) |=> !s_axi_rdata[`LOAD_BIT]
            && s_axi_rdata[`VCID_MSB:`VCID_LSB] == `VCID_VAL && s_axi_rdata[`TC_MAP_MSB:`TC_MAP_LSB] == $past(tc_map);
    endproperty
    a_load_reads_zero: assert property (p_load_reads_zero) else $error("control read wrong");

    property p_sel_legal;
        @(posedge clock) disable iff (!rst_n)
        wr_ctrl && wstrb_ff[`BYTE_SEL] |=> (arb_select == ((wdata_ff[`SEL_MSB:`SEL_LSB] == `ARB_WRR128) ? `ARB_WRR128
            : `ARB_HW_FIXED)) [*2];
    endproperty
    a_sel_legal: assert property (p_sel_legal) else $error("scheme select not sanitised");

    property p_no_timebased;
        @(posedge clock) disable iff (!rst_n)
        arb_select != `ARB_TBWRR128;
    endproperty
    a_no_timebased: assert property (p_no_timebased) else $error("time-based scheme on VC0");

    property p_reset_defaults;
        @(posedge clock)
        !rst_n |=> tc_map == `TC_MAP_RST && vc_enable && arb_select == `ARB_HW_FIXED && !pat_load;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("reset defaults wrong");

    property p_tc_autoload;
        @(posedge clock) disable iff (!rst_n)
        autoload_valid && !(wr_ctrl && wstrb_ff[`BYTE_TC]) |=> tc_map == $past(autoload_tc_map);
    endproperty
    a_tc_autoload: assert property (p_tc_autoload) else $error("autoload TC map lost");

    property p_enable_write;
        @(posedge clock) disable iff (!rst_n)
        wr_ctrl && wstrb_ff[`BYTE_EN] |=> vc_enable == $past(wdata_ff[`EN_BIT]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable not written");

    sequence s_table_written;
        pat_entry_wr ##1 tbl_status_ff;
    endsequence

    property p_tbl_set;
        @(posedge clock) disable iff (!rst_n)
        pat_entry_wr |-> s_table_written;
    endproperty
    a_tbl_set: assert property (p_tbl_set) else $error("table status did not set");

    property p_tbl_clear;
        @(posedge clock) disable iff (!rst_n)
        pat_load_done && !pat_entry_wr |=> !tbl_status_ff;
    endproperty
    a_tbl_clear: assert property (p_tbl_clear) else $error("table status did not clear");

    property p_neg_follow;
        @(posedge clock) disable iff (!rst_n)
        ##1 neg_pend_ff == $past(vc_negotiating);
    endproperty
    a_neg_follow: assert property (p_neg_follow) else $error("negotiation pending wrong");

    property p_cap_fields;
        @(posedge clock) disable iff (!rst_n)
        ext_vc_en |-> cap_word[`CAP_ARB_MSB:`CAP_ARB_LSB] == `CAP_ARB_EXT
            && cap_word[`TOFF_MSB:`TOFF_LSB] == `TOFF_EXT && cap_word[`SLOTS_MSB:`SLOTS_LSB] == max_slots_ff;
    endproperty
    a_cap_fields: assert property (p_cap_fields) else $error("VC1 capability wrong");

    property p_cap_off;
        @(posedge clock) disable iff (!rst_n)
        !ext_vc_en |-> cap_word[`AS_BIT] == 1'b0 && cap_word == '0;
    endproperty
    a_cap_off: assert property (p_cap_off) else $error("VC1 capability not zero");

    property p_read_answer;
        @(posedge clock) disable iff (!rst_n)
        ar_take |=> s_axi_rvalid && !s_axi_arready && (s_axi_rdata & `RSVD_COMMON_MASK) == 32'h0;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");

endmodule

// >>> test/test_vc_resource_config_regs.sv
// Self-checking bench for the VC resource register slice
`timescale 1ns/1ps

module test_vc_resource_config_regs;
    logic clock;
    logic rst_n;
    logic [11:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [11:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic ext_vc_en;
    logic autoload_valid;
    logic [7:0] autoload_tc_map;
    logic [6:0] autoload_max_slots;
    logic pat_entry_wr;
    logic pat_load_done;
    logic pat_load;
    logic vc_negotiating;
    logic [7:0] tc_map;
    logic [2:0] arb_select;
    logic vc_enable;
    int n_mismatch;
    int checks_done;
    logic [1:0] resp;
    logic load_seen;
    logic [31:0] rdata;

    vc_resource_config_regs #(.ADDR_WIDTH(12), .TC_MAP_WIDTH(8)) u_vc_resource_config_regs
    (
        .clock(clock), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_vc_en(ext_vc_en),
        .autoload_valid(autoload_valid), .autoload_tc_map(autoload_tc_map),
        .autoload_max_slots(autoload_max_slots), .pat_entry_wr(pat_entry_wr),
        .pat_load_done(pat_load_done), .pat_load(pat_load), .vc_negotiating(vc_negotiating),
        .tc_map(tc_map), .arb_select(arb_select), .vc_enable(vc_enable)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic apply_reset;
        @(posedge clock);
        rst_n <= 1'h0;
        repeat (2) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
    endtask

    // Write with address and data offered together, bready held until the answer
    task automatic axi_write(input logic [11:0] addr, input logic [31:0] data, input logic [3:0] strb);
        bit aw_done;
        bit w_done;
        int n;
        aw_done = 0;
        w_done = 0;
        n = 0;
        @(posedge clock);
        s_axi_awaddr <= addr;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= data;
        s_axi_wstrb <= strb;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw_done && w_done) && n < 100)
        begin
            @(posedge clock);
            n++;
            if (!aw_done && s_axi_awready === 1'h1)
            begin
                aw_done = 1;
                s_axi_awvalid <= 1'h0;
            end
            if (!w_done && s_axi_wready === 1'h1)
            begin
                w_done = 1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do
        begin
            @(posedge clock);
            n++;
        end
        while (s_axi_bvalid !== 1'h1 && n < 100);
        resp = s_axi_bresp;
        load_seen = pat_load;
        s_axi_bready <= 1'h0;
        if (n >= 100)
            chk("write answer", 32'h1, 32'h0);
    endtask

    task automatic axi_read(input logic [11:0] addr);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (s_axi_arready !== 1'h1 && n < 100);
        s_axi_arvalid <= 1'h0;
        while (s_axi_rvalid !== 1'h1 && n < 100)
        begin
            @(posedge clock);
            n++;
        end
        rdata = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        if (n >= 100)
            chk("read answer", 32'h1, 32'h0);
    endtask

    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
        axi_read(addr);
        chk($sformatf("read %h", addr), exp, rdata);
        chk("rresp", 32'h0, {30'h0, resp});
    endtask

    task automatic pulse_events(input logic entry, input logic done);
        @(posedge clock);
        pat_entry_wr <= entry;
        pat_load_done <= done;
        @(posedge clock);
        pat_entry_wr <= 1'h0;
        pat_load_done <= 1'h0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset_values;
        rd_chk(12'h154, 32'h800000ff);
        rd_chk(12'h158, 32'h00000000);
        rd_chk(12'h15c, 32'h087f0019);
        chk("outputs", {20'h0, 8'hff, 3'h0, 1'h1}, {20'h0, tc_map, arb_select, vc_enable});
        @(posedge clock);
        ext_vc_en <= 1'h0;
        rd_chk(12'h15c, 32'h00000000);
        @(posedge clock);
        ext_vc_en <= 1'h1;
        $display("test reset values done");
    endtask

    task automatic test_control_write;
        axi_write(12'h154, 32'h7ff7ff5a, 4'hf);
        chk("load pulse", 32'h1, {31'h0, load_seen});
        chk("outputs", {20'h0, 8'h5a, 3'h3, 1'h0}, {20'h0, tc_map, arb_select, vc_enable});
        rd_chk(12'h154, 32'h0006005a);
        axi_write(12'h154, 32'h80000000, 4'h8);
        chk("load pulse", 32'h0, {31'h0, load_seen});
        rd_chk(12'h154, 32'h8006005a);
        $display("test control write done");
    endtask

    task automatic test_select_codes;
        logic [2:0] exp;
        for (int i = 0; i < 8; i++)
        begin
            exp = (i == 3) ? 3'h3 : 3'h0;
            axi_write(12'h154, 32'h800000ff | (i << 17), 4'hf);
            chk("arb select", {29'h0, exp}, {29'h0, arb_select});
            rd_chk(12'h154, 32'h800000ff | ({29'h0, exp} << 17));
        end
        $display("test select codes done");
    endtask

    task automatic test_table_status;
        pulse_events(1'h1, 1'h0);
        rd_chk(12'h158, 32'h00010000);
        axi_write(12'h154, 32'h00010000, 4'h4);
        chk("load pulse", 32'h1, {31'h0, load_seen});
        rd_chk(12'h158, 32'h00010000);
        pulse_events(1'h0, 1'h1);
        rd_chk(12'h158, 32'h00000000);
        pulse_events(1'h1, 1'h1);
        rd_chk(12'h158, 32'h00010000);
        pulse_events(1'h0, 1'h1);
        rd_chk(12'h158, 32'h00000000);
        $display("test table status done");
    endtask

    task automatic test_negotiation;
        @(posedge clock);
        vc_negotiating <= 1'h1;
        rd_chk(12'h158, 32'h00020000);
        rd_chk(12'h158, 32'h00020000);
        @(posedge clock);
        vc_negotiating <= 1'h0;
        rd_chk(12'h158, 32'h00000000);
        $display("test negotiation done");
    endtask

    task automatic test_unmapped;
        axi_write(12'h160, 32'h00000000, 4'hf);
        chk("bresp", 32'h2, {30'h0, resp});
        axi_read(12'h160);
        chk("rdata", 32'h0, rdata);
        chk("rresp", 32'h2, {30'h0, resp});
        axi_write(12'h158, 32'hffffffff, 4'hf);
        chk("bresp", 32'h0, {30'h0, resp});
        rd_chk(12'h158, 32'h00000000);
        axi_write(12'h15c, 32'hffffffff, 4'hf);
        rd_chk(12'h15c, 32'h087f0019);
        rd_chk(12'h154, 32'h800000ff);
        $display("test unmapped done");
    endtask

    task automatic test_reset_autoload;
        axi_write(12'h154, 32'h0006005a, 4'hf);
        rd_chk(12'h154, 32'h0006005a);
        apply_reset();
        rd_chk(12'h154, 32'h800000ff);
        @(posedge clock);
        autoload_tc_map <= 8'h3c;
        autoload_max_slots <= 7'h15;
        autoload_valid <= 1'h1;
        @(posedge clock);
        autoload_valid <= 1'h0;
        rd_chk(12'h154, 32'h8000003c);
        rd_chk(12'h15c, 32'h08150019);
        chk("tc map", 32'h3c, {24'h0, tc_map});
        $display("test reset and autoload done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #50000;
        n_mismatch++;
        $display("timeout");
        finish_test();
    end

    initial
    begin
        rst_n <= 1'h0;
        s_axi_awaddr <= 12'h0;
        s_axi_awvalid <= 1'h0;
        s_axi_wdata <= 32'h0;
        s_axi_wstrb <= 4'h0;
        s_axi_wvalid <= 1'h0;
        s_axi_bready <= 1'h0;
        s_axi_araddr <= 12'h0;
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h0;
        ext_vc_en <= 1'h1;
        autoload_valid <= 1'h0;
        autoload_tc_map <= 8'h0;
        autoload_max_slots <= 7'h0;
        pat_entry_wr <= 1'h0;
        pat_load_done <= 1'h0;
        vc_negotiating <= 1'h0;
        apply_reset();
        test_reset_values();
        test_control_write();
        test_select_codes();
        test_table_status();
        test_negotiation();
        test_unmapped();
        test_reset_autoload();
        finish_test();
    end
endmodule
